// ### inc/lsb_pkg.sv
// Package for the legacy status byte: bit positions, reset values, carrier types
package lsb_pkg;

  // Bit positions within the status byte
  localparam int unsigned LSB_BIT_LMT    = 0;     // Limiter or oscillation
  localparam int unsigned LSB_BIT_ERR    = 1;     // Remote command error
  localparam int unsigned LSB_BIT_B2     = 2;     // Receive ready / meas_done
  localparam int unsigned LSB_BIT_B3     = 3;     // Sweep end / buffer full
  localparam int unsigned LSB_BIT_UNUSED = 4;     // Always zero
  localparam int unsigned LSB_BIT_TRIG   = 5;     // External trigger seen
  localparam int unsigned LSB_BIT_SRQ    = 6;     // Summary / service request
  localparam int unsigned LSB_BIT_OPOFF  = 7;     // External operate-off seen

  // Reset values
  localparam logic [7:0] LSB_BYTE_RST = 8'h00;    // Status byte after clear
  localparam logic [7:0] LSB_MASK_RST = 8'hbf;    // All bits enabled, bit 6 never
  localparam logic [7:0] LSB_MASK_FIX = 8'hbf;    // Bit 6 can never feed itself

  // Two-level meaning of bits 2 and 3
  typedef enum logic [0:0] {
    LSB_LEVEL0 = 1'b0,                            // Sweep end / receive ready
    LSB_LEVEL1 = 1'b1                             // Buffer full / meas_done
  } lsb_level_e;

  localparam lsb_level_e LSB_LEVEL_RST = LSB_LEVEL0;

  // Event and condition inputs from the instrument's own logic (same clock)
  typedef struct packed {
    logic       spoll_rd;                         // Serial poll read, pulse
    logic       clear_cmd;                        // Clear command, pulse
    logic       level_cmd;                        // level_select_cmds strobe
    lsb_level_e level_val;                        // Level carried by that strobe
    logic       mask_cmd;                         // status_mask_cmd strobe
    logic [7:0] mask_val;                         // 1 = bit may raise summary
    logic       srq_en;                           // Service requests enabled, level
    logic       sweep_once_done;                  // Single sweep finished, pulse
    logic       sweep_start;                      // Sweep begins, pulse
    logic       src_mode_chg;                     // Source mode changed, pulse
    logic       buf_full;                         // Measurement memory full, level
    logic       cmd_ready;                        // Can accept a command, pulse
    logic       cmd_accepted;                     // Command taken in, pulse
    logic       meas_done;                        // Measurement finished, pulse
    logic       meas_start;                       // Measurement begins, pulse
    logic       meas_data_rd;                     // Result read out, pulse
    logic       cmd_err;                          // Unknown/syntax/arg/exec error
    logic       cmd_ok_delim;                     // Valid commands to delimiter
    logic       limit_det;                        // Limiter detect, level
    logic       osc_det;                          // Oscillation detect, level
  } lsb_evt_s;

endpackage : lsb_pkg

// ### src/lsb_status_byte.sv
// Legacy-mode status byte register with serial poll clear and service request
`timescale 1ns/1ns

module lsb_status_byte
  import lsb_pkg::*;
(
  input  wire logic       MCLK,          // 20 MHz system clock
  input  wire logic       RST,           // Synchronous reset, active high
  input  wire logic       TRIG_PIN,      // External trigger pin, asynchronous
  input  wire logic       OPOFF_PIN,     // External operate-off pin, asynchronous
  input  wire lsb_evt_s   EVT,           // Events from instrument logic
  output logic [7:0]      STATUS_BYTE,   // Current status byte
  output logic            SRQ_OUT,       // Service request, level
  output lsb_level_e      LEVEL_OUT      // Active level, for software readback
);

  // Complete state of the block
  typedef struct packed {
    logic       trig_s1;                 // Trigger synchroniser stage 1
    logic       trig_s2;                 // Trigger synchroniser stage 2
    logic       trig_d;                  // Previous synchronised trigger
    logic       opoff_s1;                // Operate-off synchroniser stage 1
    logic       opoff_s2;                // Operate-off synchroniser stage 2
    logic       opoff_d;                 // Previous synchronised operate-off
    lsb_level_e level;                   // Selected level
    logic [7:0] mask;                    // Summary enable mask
    logic       opoff_b;                 // Bit 7
    logic       srq_b;                   // Bit 6
    logic       trig_b;                  // Bit 5
    logic       sweep_b;                 // Bit 3, level 0 meaning
    logic       recv_b;                  // Bit 2, level 0 meaning
    logic       meas_b;                  // Bit 2, level 1 meaning
    logic       err_b;                   // Bit 1
    logic       lmt_b;                   // Bit 0
    logic       acc_seen;                // Command accepted since bit 2 set
    logic       mstart_seen;             // Measurement started since set
    logic       mread_seen;              // Result read since set
    logic       summ_d;                  // Previous unmasked summary
    logic [7:0] byte_out;                // Registered byte for the port
    logic       srq_out;                 // Registered service request
  } lsb_state_s;

  lsb_state_s st_r;                      // Current state
  lsb_state_s st_nxt;                    // Next state

  // Assemble the visible byte from stored bits, level and memory-full level
  function automatic logic [7:0] lsb_view(input lsb_state_s s, input logic full);
    logic [7:0] v;
    v                 = LSB_BYTE_RST;
    v[LSB_BIT_OPOFF]  = s.opoff_b;
    v[LSB_BIT_SRQ]    = s.srq_b;
    v[LSB_BIT_TRIG]   = s.trig_b;
    v[LSB_BIT_UNUSED] = 1'b0;
    // Level picks which source drives bits 2 and 3
    if (s.level == LSB_LEVEL1)
    begin
      v[LSB_BIT_B3] = full;
      v[LSB_BIT_B2] = s.meas_b;
    end
    else
    begin
      v[LSB_BIT_B3] = s.sweep_b;
      v[LSB_BIT_B2] = s.recv_b;
    end
    v[LSB_BIT_ERR]    = s.err_b;
    v[LSB_BIT_LMT]    = s.lmt_b;
    return v;
  endfunction : lsb_view

  // Next-state logic; in every flag the set wins over a same-cycle clear, but the clear command beats every set except that of bit 6
  always_comb
  begin
    logic       poll;                    // Serial poll this cycle
    logic       trig_rise;               // Trigger edge, synchronised
    logic       opoff_rise;              // Operate-off edge, synchronised
    logic [7:0] view;                    // Byte as it will be seen
    logic       summ;                    // Any unmasked bit set
    poll       = EVT.spoll_rd;
    trig_rise  = st_r.trig_s2 & ~st_r.trig_d;
    opoff_rise = st_r.opoff_s2 & ~st_r.opoff_d;
    view       = 8'h00;
    summ       = 1'b0;
    st_nxt     = st_r;

    // Pins pass two flip-flops before any logic looks at them
    st_nxt.trig_s1  = TRIG_PIN;
    st_nxt.trig_s2  = st_r.trig_s1;
    st_nxt.trig_d   = st_r.trig_s2;
    st_nxt.opoff_s1 = OPOFF_PIN;
    st_nxt.opoff_s2 = st_r.opoff_s1;
    st_nxt.opoff_d  = st_r.opoff_s2;

    // Level and mask commands; kept across a clear command
    if (EVT.level_cmd)
    begin
      st_nxt.level = EVT.level_val;
    end
    if (EVT.mask_cmd)
    begin
      st_nxt.mask = EVT.mask_val & LSB_MASK_FIX;
    end

    // Bit 7: operate-off pin edge, cleared by poll
    if (opoff_rise)
    begin
      st_nxt.opoff_b = 1'b1;
    end
    else if (poll)
    begin
      st_nxt.opoff_b = 1'b0;
    end

    // Bit 5: trigger pin edge, cleared by poll
    if (trig_rise)
    begin
      st_nxt.trig_b = 1'b1;
    end
    else if (poll)
    begin
      st_nxt.trig_b = 1'b0;
    end

    // Bit 3 level 0: sweep end; any of three events clears it
    if (EVT.sweep_once_done)
    begin
      st_nxt.sweep_b = 1'b1;
    end
    else if (EVT.sweep_start | EVT.src_mode_chg | poll)
    begin
      st_nxt.sweep_b = 1'b0;
    end

    // Bit 2 level 0: ready; needs acceptance and a poll to clear
    if (EVT.cmd_ready)
    begin
      st_nxt.recv_b   = 1'b1;
      st_nxt.acc_seen = 1'b0;
    end
    else if (st_r.recv_b)
    begin
      // Acceptance may arrive before or with the poll
      if ((st_r.acc_seen | EVT.cmd_accepted) & poll)
      begin
        st_nxt.recv_b   = 1'b0;
        st_nxt.acc_seen = 1'b0;
      end
      else if (EVT.cmd_accepted)
      begin
        st_nxt.acc_seen = 1'b1;
      end
    end

    // Bit 2 level 1: meas_done; needs new start and readout to clear
    if (EVT.meas_done)
    begin
      st_nxt.meas_b      = 1'b1;
      st_nxt.mstart_seen = 1'b0;
      st_nxt.mread_seen  = 1'b0;
    end
    else if (st_r.meas_b)
    begin
      if ((st_r.mstart_seen | EVT.meas_start) & (st_r.mread_seen | EVT.meas_data_rd))
      begin
        st_nxt.meas_b      = 1'b0;
        st_nxt.mstart_seen = 1'b0;
        st_nxt.mread_seen  = 1'b0;
      end
      else
      begin
        st_nxt.mstart_seen = st_r.mstart_seen | EVT.meas_start;
        st_nxt.mread_seen  = st_r.mread_seen | EVT.meas_data_rd;
      end
    end

    // Bit 1: command error, cleared by a clean block
    if (EVT.cmd_err)
    begin
      st_nxt.err_b = 1'b1;
    end
    else if (EVT.cmd_ok_delim)
    begin
      st_nxt.err_b = 1'b0;
    end

    // Bit 0: stays up until both detections have gone
    if (EVT.limit_det | EVT.osc_det)
    begin
      st_nxt.lmt_b = 1'b1;
    end
    else
    begin
      st_nxt.lmt_b = 1'b0;
    end

    // Clear command wipes every bit; level and mask survive it
    if (EVT.clear_cmd)
    begin
      st_nxt.opoff_b     = 1'b0;
      st_nxt.srq_b       = 1'b0;
      st_nxt.trig_b      = 1'b0;
      st_nxt.sweep_b     = 1'b0;
      st_nxt.recv_b      = 1'b0;
      st_nxt.meas_b      = 1'b0;
      st_nxt.err_b       = 1'b0;
      st_nxt.lmt_b       = 1'b0;
      st_nxt.acc_seen    = 1'b0;
      st_nxt.mstart_seen = 1'b0;
      st_nxt.mread_seen  = 1'b0;
    end

    // Summary: a fresh unmasked bit raises bit 6; an edge keeps SRQ from re-firing
    view = lsb_view(st_nxt, EVT.buf_full);
    summ = |(view & st_r.mask & LSB_MASK_FIX);
    st_nxt.summ_d = summ;
    if (summ & ~st_r.summ_d)
    begin
      st_nxt.srq_b = 1'b1;
    end
    else if (poll | EVT.clear_cmd)
    begin
      st_nxt.srq_b = 1'b0;
    end
    // Clear command also resets the summary history; bit 3's memory-full view drops for that one cycle only
    if (EVT.clear_cmd)
    begin
      st_nxt.summ_d = 1'b0;
      view          = LSB_BYTE_RST;
    end

    // Output registers
    st_nxt.byte_out = lsb_view(st_nxt, EVT.buf_full & ~EVT.clear_cmd);
    st_nxt.srq_out  = st_nxt.srq_b & EVT.srq_en;
  end

  // State register; power-up reset clears everything but the mask, which loads LSB_MASK_RST
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      st_r          <= '0;
      st_r.level    <= LSB_LEVEL_RST;
      st_r.mask     <= LSB_MASK_RST;
      st_r.byte_out <= LSB_BYTE_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign STATUS_BYTE = st_r.byte_out;
  assign SRQ_OUT     = st_r.srq_out;
  assign LEVEL_OUT   = st_r.level;

endmodule : lsb_status_byte

// ### sim/lsb_status_byte_asserts.sv
// Port checker for the legacy status byte, bound to the design top
`timescale 1ns/1ns
module lsb_sb_chk
  import lsb_pkg::*;
(
  input wire logic       MCLK,
  input wire logic       RST,
  input wire logic       TRIG_PIN,
  input wire logic       OPOFF_PIN,
  input wire lsb_evt_s   EVT,
  input wire logic [7:0] STATUS_BYTE,
  input wire logic       SRQ_OUT,
  input wire lsb_level_e LEVEL_OUT
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  unused_zero_a: assert property (
    STATUS_BYTE[4] == 1'h0) else $error("unused bit set");
  reset_val_a: assert property (
    $fell(RST) |-> STATUS_BYTE == LSB_BYTE_RST && !SRQ_OUT) else $error("reset value");
  // Pin edge needs the sync stages; polls and clears kept out meanwhile
  trig_set_a: assert property (
    $rose(TRIG_PIN) ##0 (!EVT.spoll_rd && !EVT.clear_cmd)[*6] |-> STATUS_BYTE[5])
    else $error("trigger not seen");
  // Pin quiet long enough that no set is still in flight
  poll_clr_a: assert property (
    !TRIG_PIN[*4] ##0 EVT.spoll_rd |=> !STATUS_BYTE[5]) else $error("poll kept trigger");
  err_set_a: assert property (
    EVT.cmd_err && !EVT.clear_cmd |=> STATUS_BYTE[1]) else $error("error not set");
  lmt_follow_a: assert property (
    !$past(RST) && !$past(EVT.clear_cmd)
    |-> STATUS_BYTE[0] == ($past(EVT.limit_det) || $past(EVT.osc_det)))
    else $error("detect bit wrong");
  buf_full_a: assert property (
    LEVEL_OUT == LSB_LEVEL1 && $past(LEVEL_OUT) == LSB_LEVEL1 && !$past(RST)
    && !$past(EVT.clear_cmd) |-> STATUS_BYTE[3] == $past(EVT.buf_full))
    else $error("full bit wrong");
  level_cmd_a: assert property (
    EVT.level_cmd |=> LEVEL_OUT == $past(EVT.level_val)) else $error("level not taken");
  srq_sum_a: assert property (
    SRQ_OUT |-> STATUS_BYTE[6]) else $error("request without summary");
endmodule : lsb_sb_chk

bind lsb_status_byte lsb_sb_chk u_chk (.MCLK(MCLK), .RST(RST), .TRIG_PIN(TRIG_PIN),
  .OPOFF_PIN(OPOFF_PIN), .EVT(EVT), .STATUS_BYTE(STATUS_BYTE), .SRQ_OUT(SRQ_OUT),
  .LEVEL_OUT(LEVEL_OUT));

// ### sim/lsb_poller.sv
// Remote bus controller model that reads the status byte by serial poll
`timescale 1ns/1ns
module lsb_poller
  import lsb_pkg::*;
#(
  parameter int GAP = 0                  // Idle cycles before a poll, for a slow host
)
(
  input  wire logic [7:0] STATUS_IN,     // Byte presented by the device
  input  wire logic       MCLK,          // Bench clock
  output logic            SPOLL_RD       // One-cycle poll strobe
);
  initial SPOLL_RD = 1'h0;
  // Strobe spans exactly one rising edge so a poll is never counted twice
  task automatic poll(output logic [7:0] b);
    repeat (GAP) @(negedge MCLK);
    SPOLL_RD = 1'h1;
    b = STATUS_IN;
    @(negedge MCLK);
    SPOLL_RD = 1'h0;
    @(negedge MCLK);
  endtask : poll
endmodule : lsb_poller

// ### sim/tb_top.sv
// Self-checking bench for the legacy status byte
`timescale 1ns/1ns
module tb_top
  import lsb_pkg::*;
;
  localparam logic [1:0] LMT_SEQ [4] = '{2'h2, 2'h3, 2'h1, 2'h0}; // Detect walk
  logic        MCLK = 1'h0;    // Bench clock
  logic        RST = 1'h1;     // Reset, held at start
  logic        trig = 1'h0;    // Trigger pin drive
  logic        opoff = 1'h0;   // Operate-off pin drive
  lsb_evt_s    evt = '0;       // Bench pulses and levels
  lsb_evt_s    ev_d;           // Same, with the host poll merged in
  logic        spoll;          // Poll strobe from host model
  logic [7:0]  sb;             // Status byte
  logic [7:0]  pb;             // Byte returned by a poll
  logic        srq;            // Service request
  lsb_level_e  lvl;            // Level readback
  int          err_total = 0;  // Mismatches
  int          checks = 0;     // Comparisons
  int          cyc = 0;        // Hang guard
  logic [31:0] rnd = 32'h7e7e; // Random state

  lsb_status_byte u_dut (.MCLK(MCLK), .RST(RST), .TRIG_PIN(trig), .OPOFF_PIN(opoff),
    .EVT(ev_d), .STATUS_BYTE(sb), .SRQ_OUT(srq), .LEVEL_OUT(lvl));
  lsb_poller u_host (.STATUS_IN(sb), .MCLK(MCLK), .SPOLL_RD(spoll));

  always #25 MCLK = ~MCLK;
  // Only the host may poll
  always_comb
  begin
    ev_d = evt;
    ev_d.spoll_rd = spoll;
  end
  // Directed part is short; random part is 300 cycles
  always @(posedge MCLK)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_total++;
      $display("ERROR %0t run hung", $time);
      tally_and_finish();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Detect bit is the OR of both conditions
  function automatic logic exp_lmt(input logic l, input logic o);
    return l | o;
  endfunction : exp_lmt
  // Keep levels, drop pulses
  function automatic lsb_evt_s idle(input lsb_evt_s e);
    lsb_evt_s r;
    r = '0;
    r.level_val = e.level_val;
    r.mask_val = e.mask_val;
    r.srq_en = e.srq_en;
    r.buf_full = e.buf_full;
    r.limit_det = e.limit_det;
    r.osc_det = e.osc_det;
    return r;
  endfunction : idle

  task automatic chk1(input logic g, input logic e, input string m);
    checks++;
    if (g !== e)
      begin
        err_total++;
        $display("ERROR %0t %s", $time, m);
      end
  endtask : chk1
  task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
    checks++;
    if (g !== e)
      begin
        err_total++;
        $display("ERROR %0t %s got %h", $time, m, g);
      end
  endtask : chk8
  // Pulses set at a falling edge live for one rising edge, then settle
  task automatic tick();
    @(negedge MCLK);
    evt = idle(evt);
    @(negedge MCLK);
  endtask : tick
  task automatic tally_and_finish();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (2) @(negedge MCLK);
    RST = 1'h0;
    chk8(sb, LSB_BYTE_RST, "reset byte");
    chk1(srq, 1'h0, "reset srq");
    trig = 1'h1;
    tick();
    trig = 1'h0;
    repeat (4) tick();
    chk1(sb[5], 1'h1, "trigger");
    u_host.poll(pb);
    chk1(pb[5], 1'h1, "polled trigger");
    chk1(sb[5], 1'h0, "trigger clear");
    evt.cmd_err = 1'h1;
    tick();
    chk1(sb[1], 1'h1, "error set");
    evt.cmd_ok_delim = 1'h1;
    tick();
    chk1(sb[1], 1'h0, "error clear");
    for (int i = 0; i < 4; i++)
    begin
      {evt.limit_det, evt.osc_det} = LMT_SEQ[i];
      tick();
      chk1(sb[0], exp_lmt(evt.limit_det, evt.osc_det), "detect");
    end
    // Each of the three clear causes of the sweep-end bit in turn
    for (int k = 0; k < 3; k++)
    begin
      evt.sweep_once_done = 1'h1;
      tick();
      chk1(sb[3], 1'h1, "sweep end");
      evt.sweep_start = (k == 0);
      evt.src_mode_chg = (k == 1);
      if (k == 2)
        u_host.poll(pb);
      else
        tick();
      chk1(sb[3], 1'h0, "sweep clear");
    end
    evt.cmd_ready = 1'h1;
    tick();
    chk1(sb[2], 1'h1, "ready");
    u_host.poll(pb);
    chk1(sb[2], 1'h1, "ready kept by bare poll");
    evt.cmd_accepted = 1'h1;
    tick();
    u_host.poll(pb);
    chk1(sb[2], 1'h0, "ready clear");
    evt.level_cmd = 1'h1;
    evt.level_val = LSB_LEVEL1;
    tick();
    chk1(lvl, LSB_LEVEL1, "level");
    evt.buf_full = 1'h1;
    tick();
    chk1(sb[3], 1'h1, "full");
    evt.buf_full = 1'h0;
    tick();
    chk1(sb[3], 1'h0, "not full");
    evt.meas_done = 1'h1;
    tick();
    chk1(sb[2], 1'h1, "meas done");
    evt.meas_start = 1'h1;
    tick();
    chk1(sb[2], 1'h1, "meas half pair");
    evt.meas_data_rd = 1'h1;
    tick();
    chk1(sb[2], 1'h0, "meas clear");
    // Earlier bit sets left bit 6 up; poll it away so the next rise is fresh
    u_host.poll(pb);
    chk1(sb[6] | srq, 1'h0, "summary idle");
    evt.srq_en = 1'h1;
    evt.cmd_err = 1'h1;
    tick();
    chk1(sb[6] & srq, 1'h1, "summary and request");
    u_host.poll(pb);
    chk1(sb[6] | srq, 1'h0, "request clear");
    evt.clear_cmd = 1'h1;
    tick();
    chk8(sb, LSB_BYTE_RST, "clear command");
    // Mask everything: a new error must not reach the summary bit
    evt.mask_cmd = 1'h1;
    evt.mask_val = 8'h00;
    tick();
    evt.cmd_err = 1'h1;
    tick();
    chk1(sb[1], 1'h1, "masked error kept");
    chk1(sb[6] | srq, 1'h0, "masked no summary");
    // Random traffic on every event but the poll, which the host drives, and on both pins
    repeat (300)
    begin
      rnd = lfsr(rnd);
      evt = lsb_evt_s'(rnd[$bits(lsb_evt_s)-1:0]);
      trig = rnd[31];
      opoff = rnd[30];
      @(negedge MCLK);
      chk1(sb[4], 1'h0, "unused bit");
    end
    tally_and_finish();
  end
endmodule : tb_top
